// [src/esr_top.sv]
// Eight-stage one-bit shift register evaluated once per program scan
`timescale 1ns/100ps
`include "esr_cfg.svh"

// Behaviour
// - Sample serial input and shift once only on trigger low-to-high change.
// - Trigger high-to-low change leaves stages, capture and output untouched.
// - Shift sense low moves data upward, high moves data downward.
// - Upward: new bit enters first stage, others move up, last dropped.
// - Downward: new bit enters last stage, others move down, first dropped.
// - Tap output shows the configured stage, any of eight, except that reset forces it low even when the stages are retained.
// - Without retention, stages restart from initial state after power failure.
// - With retention, all eight stages together survive power failure.
module esr_top (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic I_RETAIN,
  input wire logic [`ESR_TAP_W-1:0] I_TAP_SEL,
  input wire logic I_SCAN_VALID,
  input wire esr_pkg::esr_scan_t I_SCAN,
  output logic O_SCAN_READY,
  output logic O_TAP,
  output logic [`ESR_STAGES-1:0] O_STAGES,
  output logic O_RUN
);

  // ----------------------------------------------------------------------
  // Scan-rate divider
  // ----------------------------------------------------------------------
  logic [3:0] div_reg;
  logic [3:0] div_next;
  logic scan_tick_reg;
  logic scan_tick_next;

  always_comb
  begin
    div_next = (div_reg == `ESR_SCAN_LAST) ? `ESR_DIV_RST : div_reg + 4'h1;
    scan_tick_next = (div_reg == `ESR_SCAN_LAST);
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      div_reg <= `ESR_DIV_RST;
      scan_tick_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      scan_tick_reg <= scan_tick_next;
    end
  end

  // ----------------------------------------------------------------------
  // Input sample buffer
  // ----------------------------------------------------------------------
  // The program side may post faster than scans run; the FIFO absorbs
  // bursts and back-pressures through O_SCAN_READY when full.
  logic fifo_valid;
  logic fifo_ready;
  logic [2:0] fifo_data;
  logic pop_ready;
  esr_pkg::esr_scan_t entry;
  // Run state is declared here because the pop gate below reads it
  esr_pkg::esr_state_t state_reg;
  esr_pkg::esr_state_t state_next;
  logic run_reg;
  logic run_next;

  // Entries drain at scan rate only, so one entry is one program scan
  assign pop_ready = scan_tick_reg && run_reg;

  esr_fifo #(
    .WIDTH(3),
    .DEPTH(`ESR_FIFO_DEPTH),
    .AW(`ESR_FIFO_AW)
  ) u_esr_fifo (
    .i_clk(I_SYS_CLK),
    .i_reset(I_RESET),
    .i_in_valid(I_SCAN_VALID),
    .o_in_ready(fifo_ready),
    .i_in_data(I_SCAN),
    .o_out_valid(fifo_valid),
    .i_out_ready(pop_ready),
    .o_out_data(fifo_data)
  );

  assign entry = esr_pkg::esr_scan_t'(fifo_data);

  // ----------------------------------------------------------------------
  // Run state
  // ----------------------------------------------------------------------
  // Only the reset-to-run step exists; an illegal code falls back to reset

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      esr_pkg::ESR_ST_RESET:
      begin
        state_next = esr_pkg::ESR_ST_RUN;
      end
      esr_pkg::ESR_ST_RUN:
      begin
        state_next = esr_pkg::ESR_ST_RUN;
      end
      default:
      begin
        state_next = esr_pkg::ESR_ST_RESET;
      end
    endcase
    run_next = (state_next == esr_pkg::ESR_ST_RUN);
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      state_reg <= esr_pkg::ESR_ST_RESET;
      run_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      run_reg <= run_next;
    end
  end

  // ----------------------------------------------------------------------
  // Shift stages
  // ----------------------------------------------------------------------
  logic [`ESR_STAGES-1:0] stage_reg;
  logic [`ESR_STAGES-1:0] stage_next;
  logic trig_prev_reg;
  logic trig_prev_next;
  logic tap_reg;
  logic tap_next;
  logic scan_pop;
  logic rise;
  // One source bit per stage for each direction; the end stage takes the sample
  wire logic [`ESR_STAGES-1:0] up_src;
  wire logic [`ESR_STAGES-1:0] dn_src;
  genvar g;

  generate
    for (g = 0; g < `ESR_STAGES; g = g + 1)
    begin : g_stage
      if (g == 0)
      begin : g_up_in
        assign up_src[g] = entry.serial;
      end
      else
      begin : g_up_mid
        assign up_src[g] = stage_reg[g-1];
      end
      if (g == `ESR_STAGES - 1)
      begin : g_dn_in
        assign dn_src[g] = entry.serial;
      end
      else
      begin : g_dn_mid
        assign dn_src[g] = stage_reg[g+1];
      end
    end
  endgenerate

  function automatic logic pick_stage(input logic [`ESR_STAGES-1:0] s,
                                      input logic [`ESR_TAP_W-1:0] sel);
    pick_stage = s[sel];
  endfunction

  assign scan_pop = scan_tick_reg && fifo_valid && state_reg == esr_pkg::ESR_ST_RUN;
  // Edge found against the previous scan, not the previous clock
  assign rise = scan_pop && entry.trigger && !trig_prev_reg;

  always_comb
  begin
    trig_prev_next = scan_pop ? entry.trigger : trig_prev_reg;
    stage_next = stage_reg;
    if (rise)
    begin
      if (!entry.shift_down)
      begin
        stage_next = up_src;
      end
      else
      begin
        stage_next = dn_src;
      end
    end
    tap_next = pick_stage(stage_next, I_TAP_SEL);
  end

  // Power-up is the reset; retention keeps every stage, never a subset
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      trig_prev_reg <= `ESR_TRIG_RST;
      tap_reg <= 1'b0;
      if (!I_RETAIN)
      begin
        stage_reg <= `ESR_STAGE_RST;
      end
      else
      begin
        stage_reg <= stage_reg;
      end
    end
    else
    begin
      trig_prev_reg <= trig_prev_next;
      stage_reg <= stage_next;
      tap_reg <= tap_next;
    end
  end

  assign O_SCAN_READY = fifo_ready;
  assign O_TAP = tap_reg;
  assign O_STAGES = stage_reg;
  assign O_RUN = run_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RESET);

  a_up_shift_in: assert property (
    rise && !entry.shift_down |=> O_STAGES == {$past(O_STAGES[6:0]), $past(entry.serial)})
    else $error("Upward shift wrong");

  a_down_shift_in: assert property (
    rise && entry.shift_down |=> O_STAGES == {$past(entry.serial), $past(O_STAGES[7:1])})
    else $error("Downward shift wrong");

  a_no_edge_hold: assert property (
    !rise |=> $stable(O_STAGES))
    else $error("Stages changed without rising trigger");

  a_fall_ignored: assert property (
    scan_pop && !entry.trigger && trig_prev_reg |=> $stable(O_STAGES) && $stable(O_TAP))
    else $error("Falling trigger changed state");

  a_tap_follows: assert property (
    ##1 O_TAP == O_STAGES[$past(I_TAP_SEL)])
    else $error("Tap does not match selected stage");

  a_prev_trig: assert property (
    scan_pop |=> trig_prev_reg == $past(entry.trigger))
    else $error("Previous trigger not updated");

  a_scan_period: assert property (
    scan_tick_reg |=> !scan_tick_reg [*3] ##1 scan_tick_reg)
    else $error("Scan period wrong");

  a_reset_clear: assert property (@(posedge I_SYS_CLK) disable iff (1'b0)
    I_RESET && !I_RETAIN |=> O_STAGES == `ESR_STAGE_RST)
    else $error("Non-retentive reset did not clear");

  a_reset_keep: assert property (@(posedge I_SYS_CLK) disable iff (1'b0)
    I_RESET && I_RETAIN |=> O_STAGES == $past(O_STAGES))
    else $error("Retentive reset lost stages");

  // ----------------------------------------------------------------------
  // Reset, run, history, pacing and buffer assertions
  // ----------------------------------------------------------------------
  a_run_reset: assert property (@(posedge I_SYS_CLK) disable iff (1'b0)
    I_RESET |=> !O_RUN && !O_SCAN_READY)
    else $error("Run or ready high through power-up");

  a_hist_reset: assert property (@(posedge I_SYS_CLK) disable iff (1'b0)
    I_RESET |=> !trig_prev_reg)
    else $error("Trigger history not cleared at power-up");

  a_hist_hold: assert property (
    !scan_pop |=> $stable(trig_prev_reg))
    else $error("Trigger history moved between scans");

  a_scan_gap: assert property (
    scan_pop |=> !scan_pop [*3])
    else $error("More than one entry evaluated per scan");

  a_run_holds: assert property (
    O_RUN |=> O_RUN)
    else $error("Run dropped without reset");

  a_pop_gated: assert property (
    !O_RUN |-> !scan_pop)
    else $error("Entry evaluated before run");

  a_full_nonempty: assert property (
    !O_SCAN_READY && O_RUN |-> fifo_valid)
    else $error("Buffer refuses entries while empty");

  // ----------------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------------
  c_up_shift: cover property (rise && !entry.shift_down);
  c_down_shift: cover property (rise && entry.shift_down);
  c_fifo_full: cover property (!O_SCAN_READY && O_RUN);
  c_retain_reset: cover property (@(posedge I_SYS_CLK) disable iff (1'b0)
    I_RESET && I_RETAIN && O_STAGES != 8'h00);
  c_fall_edge: cover property (scan_pop && !entry.trigger && trig_prev_reg);

endmodule

// [src/esr_cfg.svh]
// Constants for the eight-stage shift register block
`ifndef ESR_CFG_SVH
`define ESR_CFG_SVH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define ESR_STAGES 8
`define ESR_TAP_W 3
`define ESR_FIFO_DEPTH 16
`define ESR_FIFO_AW 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ESR_STAGE_RST 8'h00
`define ESR_TRIG_RST 1'b0
`define ESR_DIV_RST 4'h0

// ----------------------------------------------------------------------
// Timing: one program scan every ESR_SCAN_DIV system clocks
// ----------------------------------------------------------------------
`define ESR_SCAN_DIV 4'h4
`define ESR_SCAN_LAST 4'h3

`endif

// [src/esr_pkg.sv]
// Types shared by the shift register block
package esr_pkg;

  // One scan's worth of input levels from the circuit program
  typedef struct packed {
    logic trigger;
    logic shift_down;
    logic serial;
  } esr_scan_t;

  typedef enum logic [1:0] {
    ESR_ST_RESET = 2'h0,
    ESR_ST_RUN = 2'h1
  } esr_state_t;

endpackage

// [src/esr_fifo.sv]
// Parameterised valid/ready FIFO holding scan input samples
`timescale 1ns/100ps
`include "esr_cfg.svh"

module esr_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = `ESR_FIFO_DEPTH,
  parameter int AW = `ESR_FIFO_AW
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW-1:0] rd_ptr_next;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic ready_reg;
  logic ready_next;
  logic valid_reg;
  logic valid_next;
  logic push;
  logic pop;

  // Flags are registered so the top sees flop outputs; ready is honest
  assign push = i_in_valid && ready_reg;
  assign pop = i_out_ready && valid_reg;

  always_comb
  begin
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next = count_reg;
    if (push && !pop)
    begin
      count_next = count_reg + 1'b1;
    end
    else if (pop && !push)
    begin
      count_next = count_reg - 1'b1;
    end
    ready_next = (count_next != DEPTH[AW:0]);
    valid_next = (count_next != '0);
  end

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
      valid_reg <= 1'b0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      ready_reg <= ready_next;
      valid_reg <= valid_next;
    end
  end

  assign o_in_ready = ready_reg;
  assign o_out_valid = valid_reg;
  assign o_out_data = mem[rd_ptr_reg];

endmodule

// [sim/esr_src.sv]
// Scan sample source standing in for the upstream circuit program
`timescale 1ns/100ps
module esr_src (
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_valid,
  output esr_pkg::esr_scan_t o_scan
);
  initial
  begin
    o_valid = 1'b0;
    o_scan = 3'h0;
  end
  // Offer one sample and hold it until taken; a gap gives slow offers
  // Valid stays high at exit so back-to-back offers never toggle it
  task automatic send(input esr_pkg::esr_scan_t s, input int gap, output bit ok);
    if (gap > 0)
    begin
      o_valid = 1'b0;
      o_scan = ~o_scan;
      repeat (gap) @(posedge i_clk);
      #1;
    end
    o_valid = 1'b1;
    o_scan = s;
    // Ready is a flop output: settled here and steady up to the next edge
    for (int k = 0; k < 400 && i_ready !== 1'b1; k++)
    begin
      @(posedge i_clk);
      #1;
    end
    ok = (i_ready === 1'b1);
    @(posedge i_clk);
    #1;
  endtask
  // Released data shows a changed pattern, never the last sample
  task automatic idle;
    o_valid = 1'b0;
    o_scan = ~o_scan;
  endtask
endmodule

// [sim/esr_top_tb.sv]
// Self-checking bench for the eight-stage shift register
`timescale 1ns/100ps
`include "esr_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module esr_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic retain = 1'b0;
  logic [`ESR_TAP_W-1:0] sel = 3'h0;
  logic valid;
  esr_pkg::esr_scan_t scan;
  logic ready;
  logic tap;
  logic run;
  logic [`ESR_STAGES-1:0] stages;
  logic [`ESR_STAGES-1:0] exp_st = 8'h00;
  logic prev_trig = 1'b0;
  logic saw_full = 1'b0;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  esr_top u_esr_top (.I_SYS_CLK(clk), .I_RESET(rst), .I_RETAIN(retain),
    .I_TAP_SEL(sel), .I_SCAN_VALID(valid), .I_SCAN(scan), .O_SCAN_READY(ready),
    .O_TAP(tap), .O_STAGES(stages), .O_RUN(run));
  esr_src u_esr_src (.i_clk(clk), .i_ready(ready), .o_valid(valid), .o_scan(scan));
  // ----------------------------------------------------------------------
  // Expectation and helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] step(input logic [7:0] st, input logic pt,
    input esr_pkg::esr_scan_t s);
    if (!(s.trigger && !pt))
      return st;
    if (s.shift_down)
      return {s.serial, st[7:1]};
    return {st[6:0], s.serial};
  endfunction
  task automatic push(input esr_pkg::esr_scan_t s, input int gap);
    bit ok;
    u_esr_src.send(s, gap, ok);
    exp_st = step(exp_st, prev_trig, s);
    prev_trig = s.trigger;
    if (!ok)
    begin
      err_count++;
      complete_run();
    end
  endtask
  // Fixed wait: one entry is evaluated every four clocks
  task automatic settle(input int n);
    u_esr_src.idle();
    repeat (n) @(posedge clk);
    #1;
    `CHK(stages, exp_st)
  endtask
  task automatic do_reset(input logic r);
    retain = r;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK(run, 1'b0)
    `CHK(ready, 1'b0)
    rst = 1'b0;
    prev_trig = 1'b0;
    if (!r)
      exp_st = 8'h00;
    @(posedge clk);
    #1;
    `CHK(run, 1'b1)
    `CHK(stages, exp_st)
  endtask
  task automatic complete_run;
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (run && !ready)
      saw_full <= 1'b1;
    if (cyc > 40000)
    begin
      err_count++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    esr_pkg::esr_scan_t hand [8];
    hand = '{3'h5, 3'h5, 3'h0, 3'h7, 3'h4, 3'h0, 3'h6, 3'h1};
    void'($urandom(65509));
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    `CHK(stages, 8'h00)
    // Repeated high, falling edge and direction change, back to back
    foreach (hand[i])
      push(hand[i], 0);
    settle(30);
    for (int i = 0; i < 60; i++)
    begin
      sel = 3'($urandom);
      push(3'($urandom), $urandom % 4);
      settle(10);
      `CHK(tap, exp_st[sel])
    end
    // Burst beyond the buffer depth: the source must stall
    for (int i = 0; i < 24; i++)
      push(3'($urandom), 0);
    settle(110);
    `CHK(saw_full, 1'b1)
    for (int i = 0; i < 8; i++)
    begin
      sel = i[2:0];
      repeat (2) @(posedge clk);
      #1;
      `CHK(tap, exp_st[i])
    end
    // Trigger low first so the next entry is a sure rising edge
    push(3'h0, 0);
    push(3'h5, 0);
    settle(10);
    do_reset(1'b1);
    push(3'h7, 0);
    settle(10);
    do_reset(1'b0);
    complete_run();
  end
endmodule
